/* File: verilog/pwhf_pkg.sv */
// Operation
// [R1] ipv4 version field always four
// [R2] ipv4 header length five words, no options
// [R3] ipv4 flags driven to 010
// [R4] fragment offset unused, fragments never reassembled
// [R5] received ipv4 with zero ttl discarded
// [R6] ipv4 protocol field set to udp
// [R7] ipv4 total length covers header plus data
// [R8] ipv4 header checksum computed and inserted
// [R9] bundle id in selectable udp port, classified
// [R10] other udp port may carry 0x85e
// [R11] oam packets carry all-ones bundle id; in mpls mode the inner label keeps tx_bundle
// [R12] udp length covers udp header plus payload
// [R13] uncomputed udp checksum sent as zero
// [R14] ipv6 version field always six
// [R15] ipv6 traffic class and flow label configurable
// [R16] ipv6 next header set to udp
// [R17] ipv6 addresses are 128 bits wide
// [R18] ipv6 payload length counts header and data
// [R19] zero, one or two outer mpls labels
// [R20] bottom-of-stack bit only on final label
// [R21] inner label carries bundle id, demultiplexed
// [R22] vlan tpid standard or configured alternative accepted
// [R23] multi-byte fields sent most significant first
package pwhf_pkg;
  // =====================================================
  // header constants
  localparam logic [3:0] PWHF_IPV4_VER = 4'h4;
  localparam logic [3:0] PWHF_IPV4_IHL = 4'h5;
  localparam logic [2:0] PWHF_IPV4_FLAGS = 3'h2;
  localparam logic [12:0] PWHF_FRAG_OFS = 13'h0000;
  localparam logic [7:0] PWHF_PROTO_UDP = 8'h11;
  localparam logic [3:0] PWHF_IPV6_VER = 4'h6;
  localparam logic [15:0] PWHF_PW_PORT = 16'h085e;
  localparam logic [15:0] PWHF_TPID_STD = 16'h8100;
  localparam logic [15:0] PWHF_UDP_CSUM_OFF = 16'h0000;
  // =====================================================
  // sizes in bytes and bits
  localparam int PWHF_IPV4_BYTES = 20;
  localparam int PWHF_IPV6_BYTES = 40;
  localparam int PWHF_UDP_BYTES = 8;
  localparam int PWHF_LABEL_BYTES = 4;
  localparam int PWHF_HDR_BYTES = 48;
  localparam int PWHF_HDR_BITS = PWHF_HDR_BYTES * 8;
  localparam int PWHF_CNT_W = 6;
  // byte and bit positions inside a received network header
  localparam int PWHF_RX_VER_BYTE = 0;
  localparam int PWHF_RX_FLAG_BYTE = 6;
  localparam int PWHF_RX_FRAG_BYTE = 7;
  localparam int PWHF_RX_TTL_BYTE = 8;
  localparam int PWHF_RX_PROTO_BYTE = 9;
  localparam int PWHF_RX_NH_BYTE = 6;
  localparam int PWHF_MF_BIT = 5;
  localparam int PWHF_S_BIT = 0;
  // =====================================================
  // encapsulation modes
  typedef enum logic [1:0] {
    PWHF_UDP4,
    PWHF_UDP6,
    PWHF_MPLS
  } pwhf_mode_t;
endpackage

/* File: verilog/pwhf_rx_if.sv */
`timescale 1ns/1ns
// =====================================================
// receive byte stream and classification result
interface pwhf_rx_if;
  import pwhf_pkg::*;
  logic [7:0] data; // header byte, network order
  logic valid; // byte strobe
  logic first; // first byte of network header
  logic last; // last byte of the packet
  pwhf_mode_t mode; // expected encapsulation
  logic sel_src; // bundle id in source port
  logic done; // result pulse
  logic drop; // packet must be discarded
  logic [19:0] bundle; // classified bundle id
  modport src (output data, valid, first, last, mode, sel_src, input done, drop, bundle);
  modport chk (input data, valid, first, last, mode, sel_src, output done, drop, bundle);
endinterface

/* File: verilog/pwhf_rx_check.sv */
`timescale 1ns/1ns
// =====================================================
// receive header checker and bundle classifier
module pwhf_rx_check
  import pwhf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // stream and result
  pwhf_rx_if.chk rx
);
  logic [PWHF_CNT_W-1:0] cnt_reg, cnt_next; // byte index
  logic [7:0] hold_reg, hold_next; // previous byte
  logic [15:0] w0_reg, w0_next; // label high bytes
  logic bad_reg, bad_next; // discard condition seen
  logic found_reg, found_next; // bottom label seen
  logic [19:0] bun_reg, bun_next;
  logic done_reg, done_next;
  logic drop_reg, drop_next;
  logic [PWHF_CNT_W-1:0] idx; // index of this byte
  logic [PWHF_CNT_W-1:0] port_at; // first byte of id port
  logic bad_b; // this byte is bad
  int hlen;

  assign rx.done = done_reg;
  assign rx.drop = drop_reg;
  assign rx.bundle = bun_reg;

  // next state of the parser
  always_comb begin
    idx = rx.first ? '0 : cnt_reg;
    hlen = (rx.mode == PWHF_UDP6) ? PWHF_IPV6_BYTES : PWHF_IPV4_BYTES;
    port_at = PWHF_CNT_W'(rx.sel_src ? hlen : hlen + 2);
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    w0_next = w0_reg;
    bad_next = rx.first ? 1'b0 : bad_reg;
    found_next = rx.first ? 1'b0 : found_reg;
    bun_next = bun_reg;
    done_next = 1'b0;
    drop_next = drop_reg;
    bad_b = 1'b0;
    if (rx.valid) begin
      hold_next = rx.data;
      if (idx != '1) begin
        cnt_next = idx + 1'b1;
      end
      case (rx.mode)
        PWHF_UDP4: begin
          // version, fragments, ttl and protocol
          if (idx == PWHF_CNT_W'(PWHF_RX_VER_BYTE)) begin
            bad_b = rx.data[7:4] != PWHF_IPV4_VER;
          end
          if (idx == PWHF_CNT_W'(PWHF_RX_FLAG_BYTE)) begin
            bad_b = rx.data[PWHF_MF_BIT] || (rx.data[4:0] != '0); // [R4]
          end
          if (idx == PWHF_CNT_W'(PWHF_RX_FRAG_BYTE)) begin
            bad_b = rx.data != '0; // [R4]
          end
          if (idx == PWHF_CNT_W'(PWHF_RX_TTL_BYTE)) begin
            bad_b = rx.data == '0; // [R5]
          end
          if (idx == PWHF_CNT_W'(PWHF_RX_PROTO_BYTE)) begin
            bad_b = rx.data != PWHF_PROTO_UDP;
          end
        end
        PWHF_UDP6: begin
          if (idx == PWHF_CNT_W'(PWHF_RX_VER_BYTE)) begin
            bad_b = rx.data[7:4] != PWHF_IPV6_VER;
          end
          if (idx == PWHF_CNT_W'(PWHF_RX_NH_BYTE)) begin
            bad_b = rx.data != PWHF_PROTO_UDP;
          end
        end
        PWHF_MPLS: begin
          // walk label entries until the bottom one
          if (!found_next) begin
            case (idx[1:0])
              2'h1: w0_next = {hold_reg, rx.data};
              2'h2: begin
                if (rx.data[PWHF_S_BIT]) begin
                  found_next = 1'b1; // [R21]
                  bun_next = {w0_reg, rx.data[7:4]}; // [R21]
                end
              end
              default: w0_next = w0_reg;
            endcase
          end
        end
        default: bad_b = 1'b1;
      endcase
      // udp port holding the bundle id
      if (rx.mode != PWHF_MPLS && idx == port_at + 1'b1) begin
        bun_next = {4'h0, hold_reg, rx.data}; // [R9]
      end
      bad_next = bad_next | bad_b;
      if (rx.last) begin
        done_next = 1'b1;
        drop_next = bad_next || (rx.mode == PWHF_MPLS && !found_next);
      end
    end
  end

  // parser registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      hold_reg <= '0;
      w0_reg <= '0;
      bad_reg <= 1'b0;
      found_reg <= 1'b0;
      bun_reg <= '0;
      done_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      w0_reg <= w0_next;
      bad_reg <= bad_next;
      found_reg <= found_next;
      bun_reg <= bun_next;
      done_reg <= done_next;
      drop_reg <= drop_next;
    end
  end
endmodule

/* File: verilog/pwhf_formatter.sv */
`timescale 1ns/1ns
// =====================================================
// pseudowire network header formatter and checker
module pwhf_formatter
  import pwhf_pkg::*;
#(
  parameter int BUNDLE_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // per-bundle transmit settings
  input wire logic [1:0] tx_mode,
  input wire logic [BUNDLE_W-1:0] tx_bundle,
  input wire logic tx_oam,
  input wire logic tx_sel_src,
  input wire logic tx_use_pw_port,
  input wire logic [15:0] tx_other_port,
  input wire logic [15:0] tx_payload_len,
  input wire logic [7:0] tx_tos,
  input wire logic [15:0] tx_ident,
  input wire logic [7:0] tx_ttl,
  input wire logic [19:0] tx_flow_label,
  input wire logic [127:0] tx_src_addr,
  input wire logic [127:0] tx_dst_addr,
  input wire logic [1:0] tx_outer_cnt,
  input wire logic [19:0] tx_tun_label0,
  input wire logic [19:0] tx_tun_label1,
  input wire logic [2:0] tx_exp,
  // transmit request and byte stream
  input wire logic tx_start,
  input wire logic tx_ready,
  output logic tx_busy,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  // receive byte stream
  input wire logic [1:0] rx_mode,
  input wire logic rx_sel_src,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  output logic rx_done,
  output logic rx_drop,
  output logic [19:0] rx_bundle,
  // vlan tag check
  input wire logic [15:0] alt_tag_protocol_id,
  input wire logic [15:0] rx_tag_type,
  input wire logic rx_tag_valid,
  output logic rx_tag_ok
);
  localparam int IPV4_BITS = PWHF_IPV4_BYTES * 8;
  localparam int IPV6_BITS = PWHF_IPV6_BYTES * 8;
  localparam int UDP_BITS = PWHF_UDP_BYTES * 8;
  localparam int LABEL_BITS = PWHF_LABEL_BYTES * 8;

  typedef enum logic [0:0] {
    TX_IDLE,
    TX_SEND
  } pwhf_tx_st_t;

  // =====================================================
  // ones-complement checksum of an option-free ipv4 header
  function automatic logic [15:0] pwhf_csum(input logic [IPV4_BITS-1:0] h);
    logic [19:0] s;
    logic [19:0] s2;
    logic [15:0] f;
    s = '0;
    for (int i = 0; i < IPV4_BITS / 16; i++) begin
      s = s + {4'h0, h[i*16 +: 16]};
    end
    s2 = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
    f = s2[15:0] + {12'h000, s2[19:16]};
    return ~f;
  endfunction

  // =====================================================
  // header assembly
  pwhf_tx_st_t st_reg, st_next;
  logic [PWHF_HDR_BITS-1:0] sh_reg, sh_next; // outgoing header, msb first
  logic [PWHF_CNT_W-1:0] left_reg, left_next; // bytes still to send
  logic valid_reg, valid_next;
  logic last_reg, last_next;
  logic [PWHF_HDR_BITS-1:0] hdr; // assembled header
  logic [PWHF_CNT_W-1:0] hdr_len; // header bytes
  logic [IPV4_BITS-1:0] ip4; // ipv4 header
  logic [UDP_BITS-1:0] udp; // udp header
  logic [15:0] id_port; // port holding the bundle id
  logic [15:0] alt_port; // the other port
  logic [15:0] udp_len;
  logic [15:0] ip_len;
  logic [LABEL_BITS-1:0] lab0, lab1, lab_in; // mpls entries

  // build every header field from the settings
  always_comb begin
    id_port = tx_oam ? '1 : 16'(tx_bundle); // [R11]
    alt_port = tx_use_pw_port ? PWHF_PW_PORT : tx_other_port; // [R10]
    udp_len = 16'(PWHF_UDP_BYTES) + tx_payload_len; // [R12]
    // udp: ports, length, checksum left uncomputed
    udp = tx_sel_src ? {id_port, alt_port, udp_len, PWHF_UDP_CSUM_OFF} // [R9] [R13]
                     : {alt_port, id_port, udp_len, PWHF_UDP_CSUM_OFF}; // [R9] [R13]
    ip_len = 16'(PWHF_IPV4_BYTES) + udp_len; // [R7]
    // ipv4 with checksum field zero for the sum
    ip4 = {PWHF_IPV4_VER, PWHF_IPV4_IHL, tx_tos, ip_len, tx_ident, // [R1] [R2]
           PWHF_IPV4_FLAGS, PWHF_FRAG_OFS, tx_ttl, PWHF_PROTO_UDP, // [R3] [R4] [R6]
           16'h0000, tx_src_addr[31:0], tx_dst_addr[31:0]};
    ip4[79:64] = pwhf_csum(ip4); // [R8]
    // mpls entries: label, exp, bottom bit, ttl
    lab0 = {tx_tun_label0, tx_exp, 1'b0, tx_ttl}; // [R20]
    lab1 = {tx_tun_label1, tx_exp, 1'b0, tx_ttl}; // [R20]
    lab_in = {20'(tx_bundle), tx_exp, 1'b1, tx_ttl}; // [R20] [R21]
    hdr = '0;
    hdr_len = '0;
    case (tx_mode)
      PWHF_UDP4: begin
        hdr[PWHF_HDR_BITS-1 -: IPV4_BITS + UDP_BITS] = {ip4, udp}; // [R23]
        hdr_len = PWHF_CNT_W'(PWHF_IPV4_BYTES + PWHF_UDP_BYTES);
      end
      PWHF_UDP6: begin
        // length counts header and data, like ipv4 total length
        hdr[PWHF_HDR_BITS-1 -: IPV6_BITS + UDP_BITS] = {PWHF_IPV6_VER, tx_tos, // [R14] [R15]
          tx_flow_label, 16'(PWHF_IPV6_BYTES) + udp_len, // [R15] [R18]
          PWHF_PROTO_UDP, tx_ttl, tx_src_addr, tx_dst_addr, udp}; // [R16] [R17] [R23]
        hdr_len = PWHF_CNT_W'(PWHF_IPV6_BYTES + PWHF_UDP_BYTES);
      end
      PWHF_MPLS: begin
        // outer labels ahead of the inner one
        case (tx_outer_cnt)
          2'h1: begin
            hdr[PWHF_HDR_BITS-1 -: 2 * LABEL_BITS] = {lab0, lab_in}; // [R19]
            hdr_len = PWHF_CNT_W'(2 * PWHF_LABEL_BYTES);
          end
          2'h2: begin
            hdr[PWHF_HDR_BITS-1 -: 3 * LABEL_BITS] = {lab0, lab1, lab_in}; // [R19]
            hdr_len = PWHF_CNT_W'(3 * PWHF_LABEL_BYTES);
          end
          default: begin
            hdr[PWHF_HDR_BITS-1 -: LABEL_BITS] = lab_in; // [R19]
            hdr_len = PWHF_CNT_W'(PWHF_LABEL_BYTES);
          end
        endcase
      end
      default: begin
        hdr = '0;
        hdr_len = '0;
      end
    endcase
  end

  // =====================================================
  // transmit byte sequencer
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    left_next = left_reg;
    valid_next = valid_reg;
    last_next = last_reg;
    case (st_reg)
      TX_IDLE: begin
        // latch the header on a start request
        if (tx_start && hdr_len != '0) begin
          st_next = TX_SEND;
          sh_next = hdr;
          left_next = hdr_len;
          valid_next = 1'b1;
          last_next = hdr_len == PWHF_CNT_W'(1);
        end
      end
      TX_SEND: begin
        // shift one byte out per accepted beat
        if (tx_ready) begin
          sh_next = sh_reg << 8; // [R23]
          left_next = left_reg - 1'b1;
          last_next = left_reg == PWHF_CNT_W'(2);
          if (last_reg) begin
            st_next = TX_IDLE;
            valid_next = 1'b0;
            last_next = 1'b0;
          end
        end
      end
      default: begin
        st_next = TX_IDLE;
        valid_next = 1'b0;
        last_next = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= TX_IDLE;
      sh_reg <= '0;
      left_reg <= '0;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      left_reg <= left_next;
      valid_reg <= valid_next;
      last_reg <= last_next;
    end
  end

  assign tx_data = sh_reg[PWHF_HDR_BITS-1 -: 8];
  assign tx_valid = valid_reg;
  assign tx_last = last_reg;
  assign tx_busy = valid_reg;

  // =====================================================
  // receive classification
  pwhf_rx_if rxi ();
  assign rxi.data = rx_data;
  assign rxi.valid = rx_valid;
  assign rxi.first = rx_first;
  assign rxi.last = rx_last;
  assign rxi.mode = pwhf_mode_t'(rx_mode);
  assign rxi.sel_src = rx_sel_src;

  pwhf_rx_check u_rx_check (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rx(rxi.chk)
  );

  assign rx_done = rxi.done;
  assign rx_drop = rxi.drop;
  assign rx_bundle = rxi.bundle;

  // =====================================================
  // vlan tag protocol id check
  logic tag_ok_reg, tag_ok_next;

  always_comb begin
    tag_ok_next = tag_ok_reg;
    if (rx_tag_valid) begin
      tag_ok_next = (rx_tag_type == PWHF_TPID_STD) || // [R22]
                    (rx_tag_type == alt_tag_protocol_id); // [R22]
    end
  end

  // tag result register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tag_ok_reg <= 1'b0;
    end else begin
      tag_ok_reg <= tag_ok_next;
    end
  end

  assign rx_tag_ok = tag_ok_reg;
endmodule

/* File: verif/pwhf_formatter_properties.sv */
`timescale 1ns/1ns
// ==============================
// port checks of the header formatter
module pwhf_formatter_properties
  import pwhf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // transmit stream
  input wire logic [1:0] tx_mode,
  input wire logic tx_start,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  // receive result
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_done,
  input wire logic rx_drop,
  // tag check
  input wire logic [15:0] alt_tag_protocol_id,
  input wire logic [15:0] rx_tag_type,
  input wire logic rx_tag_valid,
  input wire logic rx_tag_ok
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // first byte of a header follows an accepted start
  chk_v4_first_byte: assert property (
    !tx_valid && tx_start && tx_mode == 2'h0 |=> tx_valid && tx_data == 8'h45)
    else $error("ipv4 header does not open with 45");
  chk_v6_first_nibble: assert property (
    !tx_valid && tx_start && tx_mode == 2'h1 |=> tx_valid && tx_data[7:4] == 4'h6)
    else $error("ipv6 header does not open with 6");
  // a refused byte stands unchanged
  chk_byte_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("byte changed while not accepted");
  chk_frame_ends: assert property (
    tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("stream ran past the last byte");
  // receive result timing
  chk_rx_answer: assert property (
    rx_valid && rx_last |=> rx_done ##1 !rx_done)
    else $error("result pulse missing or too long");
  chk_drop_held: assert property (
    !rx_done && !$past(sys_rst) |-> rx_drop == $past(rx_drop))
    else $error("drop moved without a result");
  chk_done_cause: assert property (
    rx_done |-> $past(rx_valid && rx_last))
    else $error("result without a final byte");
  chk_tag_accept: assert property (
    rx_tag_valid |=> rx_tag_ok == ($past(rx_tag_type) == PWHF_TPID_STD
      || $past(rx_tag_type) == $past(alt_tag_protocol_id)))
    else $error("tag verdict wrong");
  cov_tx_frame: cover property (tx_valid && tx_ready && tx_last);
  cov_rx_drop: cover property (rx_done && rx_drop);
  cov_rx_keep: cover property (rx_done && !rx_drop);
endmodule

/* File: verif/pwhf_remote_end.sv */
`timescale 1ns/1ns
// ==============================
// remote pseudowire end: packet sink and source
module pwhf_remote_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // stream from the formatter
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // stream toward the checker
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  output logic rx_last
);
  logic stall = 1'b0; // slow sink when set
  logic [7:0] cap [0:63]; // captured bytes
  int cap_n = 0; // count captured
  logic got_last = 1'b0; // final byte taken
  int tick = 0; // stall pattern
  initial begin
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
  end
  // take bytes on the accepting edge, move ready just after it
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      cap[cap_n] = tx_data;
      cap_n = cap_n + 1;
      got_last = got_last | tx_last;
    end
    tick = tick + 1;
    tx_ready <= #1 !stall || (tick % 3 == 0);
  end
  // send bytes; an idle line shows the inverse of its last value
  task automatic send(input logic [7:0] b [0:49], input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      rx_data = b[i];
      rx_valid = 1'b1;
      rx_first = (i == 0);
      rx_last = (i == n - 1);
    end
    @(posedge ref_clk);
    #1;
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

/* File: verif/test_pseudowire_header_formatter.sv */
`timescale 1ns/1ns
// ==============================
// self-checking bench of the header formatter
module test_pseudowire_header_formatter;
  import pwhf_pkg::*;
  // transmit case beside its header length
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] outer;
    logic sel;
    logic oam;
    logic pw;
    logic [15:0] plen;
    logic [7:0] n;
  } pwhf_row_t;
  // receive case: source row, corrupted byte, xor mask, drop
  typedef struct packed {
    logic [2:0] row;
    logic [5:0] idx;
    logic [7:0] mask;
    logic drop;
  } pwhf_rxrow_t;
  pwhf_row_t rows [0:7] = '{'{0, 0, 1, 0, 1, 32, 28}, '{0, 0, 0, 1, 0, 0, 28},
    '{1, 0, 1, 0, 0, 100, 48}, '{1, 0, 0, 0, 1, 4, 48}, '{2, 0, 0, 0, 0, 0, 4},
    '{2, 1, 0, 0, 0, 0, 8}, '{2, 2, 0, 0, 0, 0, 12}, '{2, 3, 0, 0, 0, 0, 4}};
  pwhf_rxrow_t rxr [0:10] = '{'{0, 0, 0, 0}, '{0, 8, 8'h40, 1}, '{0, 6, 8'h20, 1},
    '{0, 7, 8'h01, 1}, '{0, 9, 8'h17, 1}, '{0, 0, 8'h10, 1}, '{1, 0, 0, 0},
    '{3, 0, 0, 0}, '{2, 6, 8'h01, 1}, '{6, 0, 0, 0}, '{6, 10, 8'h01, 1}};
  // clock, reset, counters
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  // design inputs and outputs
  logic [1:0] tx_mode, tx_outer_cnt, rx_mode;
  logic tx_oam, tx_sel_src, tx_use_pw_port, tx_start, rx_sel_src, rx_tag_valid;
  logic [15:0] tx_bundle, tx_other_port, tx_payload_len, tx_ident;
  logic [15:0] alt_tag_protocol_id, rx_tag_type;
  logic [7:0] tx_tos, tx_ttl, tx_data, rx_data;
  logic [19:0] tx_flow_label, tx_tun_label0, tx_tun_label1, rx_bundle;
  logic [127:0] tx_src_addr, tx_dst_addr;
  logic [2:0] tx_exp;
  logic tx_ready, tx_busy, tx_valid, tx_last, rx_valid, rx_first, rx_last;
  logic rx_done, rx_drop, rx_tag_ok;
  logic [7:0] eb [0:49]; // expected header bytes
  int en; // expected byte count
  always #5 ref_clk = ~ref_clk;
  pwhf_formatter dut (.*);
  pwhf_remote_end far (.*);
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  // print the verdict and end the run
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // append bytes, most significant first
  task automatic put(input logic [31:0] v);
    int i;
    for (i = 3; i >= 0; i--) begin
      eb[en] = v[8*i +: 8];
      en++;
    end
  endtask
  // drive the settings of one row, varied by its index
  task automatic set_row(input int k);
    tx_mode = rows[k].mode;
    rx_mode = rows[k].mode;
    tx_outer_cnt = rows[k].outer;
    tx_sel_src = rows[k].sel;
    rx_sel_src = rows[k].sel;
    tx_oam = rows[k].oam;
    tx_use_pw_port = rows[k].pw;
    tx_payload_len = rows[k].plen;
    tx_bundle = 16'h1230 + 16'(k);
    tx_other_port = 16'h4320 + 16'(k);
    tx_tos = 8'hb0 + 8'(k);
    tx_ident = 16'h0a00 + 16'(k);
    tx_flow_label = 20'h5a5a0 + 20'(k);
    tx_src_addr = {4{32'h0a000001 + 32'(k)}};
    tx_dst_addr = ~tx_src_addr;
    tx_tun_label0 = 20'h11110 + 20'(k);
    tx_tun_label1 = 20'h22220 + 20'(k);
  endtask
  // work out the header expected for the current settings
  task automatic build();
    logic [15:0] bp, op;
    logic [31:0] cs;
    int i;
    en = 0;
    bp = tx_oam ? 16'hffff : tx_bundle;
    op = tx_use_pw_port ? PWHF_PW_PORT : tx_other_port;
    if (tx_mode == 2'h0) begin
      put({8'h45, tx_tos, 16'd28 + tx_payload_len});
      put({tx_ident, 16'h4000});
      put({tx_ttl, 8'h11, 16'h0000});
      put(tx_src_addr[31:0]);
      put(tx_dst_addr[31:0]);
      cs = 0;
      for (i = 0; i < 20; i += 2) cs += {16'h0, eb[i], eb[i + 1]};
      cs = cs[15:0] + cs[31:16];
      cs = cs[15:0] + cs[31:16];
      {eb[10], eb[11]} = ~cs[15:0];
    end else if (tx_mode == 2'h1) begin
      put({4'h6, tx_tos, tx_flow_label});
      put({16'd48 + tx_payload_len, 8'h11, tx_ttl});
      for (i = 3; i >= 0; i--) put(tx_src_addr[32*i +: 32]);
      for (i = 3; i >= 0; i--) put(tx_dst_addr[32*i +: 32]);
    end else begin
      if (tx_outer_cnt == 2'h1 || tx_outer_cnt == 2'h2) put({tx_tun_label0, tx_exp, 1'b0, tx_ttl});
      if (tx_outer_cnt == 2'h2) put({tx_tun_label1, tx_exp, 1'b0, tx_ttl});
      put({4'h0, tx_bundle, tx_exp, 1'b1, tx_ttl});
    end
    if (tx_mode != 2'h2) begin
      put(tx_sel_src ? {bp, op} : {op, bp});
      put({16'd8 + tx_payload_len, PWHF_UDP_CSUM_OFF});
    end
  endtask
  // compare captured bytes in a range
  task automatic cmp(input int lo, input int hi);
    int t;
    for (t = lo; t < hi && t < en; t++) check("tx byte", far.cap[t], eb[t]);
  endtask
  // send one header and compare what the far end took
  task automatic run_tx(input int k);
    int t;
    set_row(k);
    build();
    far.cap_n = 0;
    far.got_last = 1'b0;
    far.stall = k[0];
    tx_start = 1'b1;
    @(posedge ref_clk);
    #1;
    tx_start = 1'b0;
    check("tx busy", tx_busy, (rows[k].mode != 2'h3));
    for (t = 0; t < 300 && !far.got_last; t++) @(posedge ref_clk);
    #1;
    check("tx length", far.cap_n, {24'h0, rows[k].n});
    cmp(0, 12);
    cmp(12, 64);
    @(posedge ref_clk);
    #1;
  endtask
  // receive one header, maybe corrupted, and judge the result
  task automatic run_rx(input int r);
    set_row(rxr[r].row);
    build();
    eb[en] = 8'h5a;
    eb[en + 1] = 8'ha5;
    eb[rxr[r].idx] ^= rxr[r].mask;
    far.send(eb, en + 2);
    check("rx done", rx_done, 1);
    check("rx drop", rx_drop, rxr[r].drop);
    if (!rxr[r].drop) check("rx bundle", rx_bundle, tx_oam ? 32'hffff : tx_bundle);
  endtask
  // main sequence
  initial begin
    int k;
    set_row(0);
    tx_start = 1'b0;
    tx_exp = 3'h5;
    tx_ttl = 8'h40;
    rx_tag_valid = 1'b0;
    rx_tag_type = 16'h0000;
    alt_tag_protocol_id = 16'h9100;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    check("reset outputs", {tx_valid, tx_data, rx_done, rx_drop, rx_bundle, rx_tag_ok}, 0);
    for (k = 0; k < 8; k++) run_tx(k);
    for (k = 0; k < 11; k++) run_rx(k);
    rx_tag_valid = 1'b1;
    for (k = 0; k < 4; k++) begin
      rx_tag_type = (k == 0) ? PWHF_TPID_STD : (k == 2) ? 16'h9100 : 16'h88a8 + 16'(k);
      @(posedge ref_clk);
      #1;
      check("tag ok", rx_tag_ok, !k[0]);
    end
    rx_tag_valid = 1'b0;
    // reset in mid frame clears every output
    set_row(0);
    far.stall = 1'b1;
    tx_start = 1'b1;
    @(posedge ref_clk);
    #1;
    tx_start = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b1;
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    check("mid reset", {tx_valid, tx_last, tx_busy, tx_data, rx_drop, rx_bundle}, 0);
    // unused mode: start ignored, receive dropped
    tx_mode = 2'h3;
    tx_start = 1'b1;
    @(posedge ref_clk);
    #1;
    tx_start = 1'b0;
    check("tx mode 3 idle", {tx_busy, tx_valid}, 0);
    rx_mode = 2'h3;
    far.send(eb, en + 2);
    check("rx mode 3 done", rx_done, 1);
    check("rx mode 3 drop", rx_drop, 1);
    stop_test();
  end
endmodule
bind pwhf_formatter pwhf_formatter_properties chk_i (.*);
